// File: src/pch_card_dev.sv
// Card end: attribute memory, configuration register and I/O cycle control.
`default_nettype none
module pch_card_dev #(
  parameter int ATTR_WORDS = 64
) (
  input  wire logic                  mclk,
  input  wire logic                  rst_b,
  pch_link_if.card                   link,
  output logic                       io_req,
  output logic                       io_wr,
  output logic [pch_pkg::AW-1:0]     io_addr,
  output logic [pch_pkg::DW-1:0]     io_wdata,
  output logic [1:0]                 io_be,
  input  wire logic                  io_ack,
  input  wire logic [pch_pkg::DW-1:0] io_rdata,
  output logic                       io_mode,
  output logic [7:0]                 card_config
);
  import pch_pkg::*;

  localparam int AIW = $clog2(ATTR_WORDS);

  logic [7:0]    attr_mem [ATTR_WORDS];
  pch_dev_st_t   st_q, st_d;
  logic [3:0]    strb_q, strb_d;
  logic [7:0]    cfg_q, cfg_d;
  logic          mode_q, mode_d;
  logic          req_q, req_d;
  logic          wr_q, wr_d;
  logic          swap_q, swap_d;
  logic [10:0]   addr_q, addr_d;
  logic [15:0]   wdata_q, wdata_d;
  logic [1:0]    be_q, be_d;
  logic [15:0]   rdata_q, rdata_d;
  logic [15:0]   dout_q, dout_d;
  logic          doe_q, doe_d;
  logic          wait_b_q, wait_b_d;
  logic          mem_we;
  logic [AIW-1:0] idx;
  logic          hw_rst;
  logic          word;
  logic          sel;
  logic          attr_ok;
  logic          io_ok;
  logic          swap;
  logic [3:0]    strb;
  logic [3:0]    fall;
  logic [10:0]   a;
  logic [15:0]   d;

  // ------------------------------------------------------------------
  // Decode and next state
  // ------------------------------------------------------------------
  always_comb
  begin
    a       = link.card_address_bus;
    d       = link.card_data_bus;
    hw_rst  = link.primary_hw_reset | link.secondary_hw_reset; // see [R13]
    word    = ~link.ce1_b & ~link.ce2_b;
    sel     = ~link.ce1_b | ~link.ce2_b;
    // Attribute bytes live on the even lane only; odd bytes are refused.
    attr_ok = ~link.reg_b & ~link.ce1_b & (word | ~a[0]); // see [R3] [R8] [R9]
    io_ok   = mode_q & ~link.reg_b & sel; // see [R8] [R14]
    swap    = ~word & ~link.ce1_b & a[0];
    idx     = a[AIW:1]; // see [R2]
    strb    = {link.oe_b, link.we_b, link.iord_b, link.iowr_b};
    fall    = strb_q & ~strb;
    strb_d  = strb;
    st_d    = st_q;
    cfg_d   = cfg_q;
    mode_d  = mode_q;
    req_d   = 1'b0;
    wr_d    = wr_q;
    swap_d  = swap_q;
    addr_d  = addr_q;
    wdata_d = wdata_q;
    be_d    = be_q;
    rdata_d = rdata_q;
    wait_b_d = wait_b_q;
    mem_we  = 1'b0;
    // Attribute read drives data on the low byte with the high byte zero, and only under the strobe.
    dout_d  = {8'h00, attr_mem[idx]};
    if ({a[10:1], 1'b0} == CFG_REG_ADDR)
    begin
      dout_d = {8'h00, cfg_q};
    end
    doe_d   = attr_ok & ~link.oe_b; // see [R5]
    if (attr_ok && fall[2]) // see [R6]
    begin
      if ({a[10:1], 1'b0} == CFG_REG_ADDR)
      begin
        cfg_d  = d[7:0];
        mode_d = 1'b1; // see [R16]
      end
      else
      begin
        mem_we = 1'b1;
      end
    end
    case (st_q)
      PCH_DV_IDLE:
      begin
        if (io_ok && (fall[1] || fall[0])) // see [R14]
        begin
          req_d    = 1'b1;
          wr_d     = fall[0];
          swap_d   = swap;
          addr_d   = word ? {a[10:1], 1'b0} : a; // see [R2]
          be_d     = word ? 2'b11 : ((~link.ce1_b && !a[0]) ? 2'b01 : 2'b10); // see [R3]
          wdata_d  = swap ? {d[7:0], 8'h00} : d;
          wait_b_d = 1'b0; // see [R15]
          st_d     = PCH_DV_BUSY;
        end
      end
      PCH_DV_BUSY:
      begin
        if (io_ack)
        begin
          rdata_d  = swap_q ? {io_rdata[7:0], io_rdata[15:8]} : io_rdata;
          wait_b_d = 1'b1; // see [R15]
          st_d     = PCH_DV_HOLD;
          // Read data stands on the bus as wait is released, so the host's sample finds it.
          if (!wr_q && io_ok && !link.iord_b)
          begin
            dout_d = swap_q ? {io_rdata[7:0], io_rdata[15:8]} : io_rdata;
            doe_d  = 1'b1;
          end
        end
      end
      PCH_DV_HOLD:
      begin
        if (!wr_q && io_ok && !link.iord_b)
        begin
          dout_d = rdata_q;
          doe_d  = 1'b1;
        end
        if (link.iord_b && link.iowr_b)
        begin
          st_d = PCH_DV_IDLE;
        end
      end
      default:
      begin
        st_d = PCH_DV_IDLE;
      end
    endcase
    if (hw_rst) // see [R11]
    begin
      cfg_d    = CFG_RST;
      mode_d   = 1'b0;
      st_d     = PCH_DV_IDLE;
      req_d    = 1'b0;
      wait_b_d = 1'b1;
      doe_d    = 1'b0;
      mem_we   = 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q     <= PCH_DV_IDLE;
      strb_q   <= 4'hF;
      cfg_q    <= CFG_RST;
      mode_q   <= 1'b0;
      req_q    <= 1'b0;
      wr_q     <= 1'b0;
      swap_q   <= 1'b0;
      addr_q   <= 11'h000;
      wdata_q  <= 16'h0000;
      be_q     <= 2'h0;
      rdata_q  <= 16'h0000;
      dout_q   <= 16'h0000;
      doe_q    <= 1'b0;
      wait_b_q <= 1'b1;
    end
    else
    begin
      st_q     <= st_d;
      strb_q   <= strb_d;
      cfg_q    <= cfg_d;
      mode_q   <= mode_d;
      req_q    <= req_d;
      wr_q     <= wr_d;
      swap_q   <= swap_d;
      addr_q   <= addr_d;
      wdata_q  <= wdata_d;
      be_q     <= be_d;
      rdata_q  <= rdata_d;
      dout_q   <= dout_d;
      doe_q    <= doe_d;
      wait_b_q <= wait_b_d;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (mem_we)
    begin
      attr_mem[idx] <= d[7:0]; // see [R9]
    end
  end

  assign link.card_data_out = dout_q; // see [R1]
  assign link.card_data_oe  = doe_q;
  assign link.wait_b        = wait_b_q;
  assign io_req             = req_q;
  assign io_wr              = wr_q;
  assign io_addr            = addr_q;
  assign io_wdata           = wdata_q;
  assign io_be              = be_q;
  assign io_mode            = mode_q;
  assign card_config        = cfg_q;
endmodule : pch_card_dev
`default_nettype wire

// File: shared/pch_pkg.sv
// Constants and types shared by both ends of the card link.
// Contract
// [R1] Data bus is 16 bits, bit 15 most significant.
// [R2] Address is 11 bits; A0 ignored on words.
// [R3] First enable even bytes, second odd bytes.
// [R4] Host holds enables high 20 ms after reset.
// [R5] Attribute read data driven only during output strobe.
// [R6] Attribute write only on write strobe.
// [R7] Host keeps register select high for common memory.
// [R8] Select low maps strobes to attribute or I/O.
// [R9] Attribute bytes even only; odd byte access refused.
// [R10] Host keeps select high on DMA I/O strobes.
// [R11] Primary reset clears config, returns memory-only mode.
// [R12] Host holds primary reset 1 ms at power-up.
// [R13] Secondary reset ORed with primary reset.
// [R14] I/O strobes ignored until configuration written.
// [R15] Wait driven low to stretch I/O cycle.
// [R16] Attribute write at config location enters I/O mode.
`default_nettype none
package pch_pkg;
  localparam int          DW           = 16;
  localparam int          AW           = 11;
  localparam logic [10:0] CFG_REG_ADDR = 11'h200;
  localparam logic [7:0]  CFG_RST      = 8'h00;
  localparam int unsigned CLK_MHZ      = 200;
  localparam int unsigned INIT_TIME_MS = 20;
  localparam int unsigned INIT_CYC     = INIT_TIME_MS * CLK_MHZ * 1000;
  localparam int unsigned PWR_RST_MS   = 1;
  localparam int unsigned PWR_RST_CYC  = PWR_RST_MS * CLK_MHZ * 1000;
  localparam int unsigned STROBE_CYC   = 4;

  typedef enum logic [1:0] {
    PCH_ATTR_RD = 2'b00,
    PCH_ATTR_WR = 2'b01,
    PCH_IO_RD   = 2'b10,
    PCH_IO_WR   = 2'b11
  } pch_cmd_t;

  typedef enum logic [1:0] {
    PCH_DV_IDLE = 2'b00,
    PCH_DV_BUSY = 2'b01,
    PCH_DV_HOLD = 2'b10
  } pch_dev_st_t;

  typedef enum logic [2:0] {
    PCH_H_PWR   = 3'b000,
    PCH_H_INIT  = 3'b001,
    PCH_H_IDLE  = 3'b010,
    PCH_H_SETUP = 3'b011,
    PCH_H_STRB  = 3'b100,
    PCH_H_REL   = 3'b101
  } pch_host_st_t;
endpackage : pch_pkg
`default_nettype wire

// File: shared/pch_link_if.sv
// Card socket link between host and card, with data bus resolution.
`default_nettype none
interface pch_link_if;
  logic [15:0] host_data_out;
  logic        host_data_oe;
  logic [15:0] card_data_out;
  logic        card_data_oe;
  logic [15:0] card_data_bus;
  logic [10:0] card_address_bus;
  logic        ce1_b;
  logic        ce2_b;
  logic        reg_b;
  logic        oe_b;
  logic        we_b;
  logic        iord_b;
  logic        iowr_b;
  logic        wait_b;
  logic        primary_hw_reset;
  logic        secondary_hw_reset;

  // Undriven lines settle low through the pull-downs.
  assign card_data_bus = card_data_oe ? card_data_out :
                         host_data_oe ? host_data_out : 16'h0000;

  modport card (
    input  card_data_bus, card_address_bus, ce1_b, ce2_b, reg_b, oe_b, we_b,
    input  iord_b, iowr_b, primary_hw_reset, secondary_hw_reset,
    output card_data_out, card_data_oe, wait_b
  );
  modport host (
    input  card_data_bus, wait_b,
    output host_data_out, host_data_oe, card_address_bus, ce1_b, ce2_b, reg_b,
    output oe_b, we_b, iord_b, iowr_b, primary_hw_reset, secondary_hw_reset
  );
endinterface : pch_link_if
`default_nettype wire

// File: src/pch_card_host.sv
// Host socket end: power-up sequencing and attribute and I/O cycles.
`default_nettype none
module pch_card_host #(
  parameter int unsigned INIT_CYC_P = pch_pkg::INIT_CYC,
  parameter int unsigned RST_CYC_P  = pch_pkg::PWR_RST_CYC
) (
  input  wire logic                   mclk,
  input  wire logic                   rst_b,
  pch_link_if.host                    link,
  input  wire logic                   cmd_valid,
  input  wire pch_pkg::pch_cmd_t      cmd_kind,
  input  wire logic [pch_pkg::AW-1:0] cmd_addr,
  input  wire logic [pch_pkg::DW-1:0] cmd_wdata,
  input  wire logic [1:0]             cmd_lanes,
  input  wire logic                   sec_reset,
  output logic                        cmd_ready,
  output logic                        rsp_valid,
  output logic [pch_pkg::DW-1:0]      rsp_data
);
  import pch_pkg::*;

  pch_host_st_t st_q, st_d;
  logic [31:0]  cnt_q, cnt_d;
  pch_cmd_t     kind_q, kind_d;
  logic [10:0]  addr_q, addr_d;
  logic [1:0]   ce_b_q, ce_b_d;
  logic         reg_b_q, reg_b_d;
  logic [3:0]   strb_b_q, strb_b_d;
  logic [15:0]  dout_q, dout_d;
  logic         doe_q, doe_d;
  logic         prst_q, prst_d;
  logic         srst_q, srst_d;
  logic         rdy_q, rdy_d;
  logic         rsp_q, rsp_d;
  logic [15:0]  rdata_q, rdata_d;

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  always_comb
  begin
    st_d     = st_q;
    cnt_d    = cnt_q + 32'h1;
    kind_d   = kind_q;
    addr_d   = addr_q;
    ce_b_d   = ce_b_q;
    reg_b_d  = reg_b_q;
    strb_b_d = strb_b_q;
    dout_d   = dout_q;
    doe_d    = doe_q;
    prst_d   = prst_q;
    srst_d   = sec_reset;
    rdy_d    = 1'b0;
    rsp_d    = 1'b0;
    rdata_d  = rdata_q;
    case (st_q)
      PCH_H_PWR:
      begin
        if (cnt_q >= RST_CYC_P - 1) // see [R12]
        begin
          prst_d = 1'b0;
          cnt_d  = 32'h0;
          st_d   = PCH_H_INIT;
        end
      end
      PCH_H_INIT:
      begin
        ce_b_d = 2'b11; // see [R4]
        if (cnt_q >= INIT_CYC_P - 1)
        begin
          rdy_d = 1'b1;
          st_d  = PCH_H_IDLE;
        end
      end
      PCH_H_IDLE:
      begin
        rdy_d = 1'b1;
        if (cmd_valid && cmd_ready)
        begin
          rdy_d   = 1'b0;
          kind_d  = cmd_kind;
          addr_d  = cmd_addr;
          ce_b_d  = ~cmd_lanes;
          reg_b_d = 1'b0; // see [R8]
          dout_d  = cmd_wdata;
          doe_d   = cmd_kind[0];
          st_d    = PCH_H_SETUP;
        end
      end
      PCH_H_SETUP:
      begin
        cnt_d    = 32'h0;
        strb_b_d = ~(4'b1000 >> kind_q); // oe, we, iord, iowr
        st_d     = PCH_H_STRB;
      end
      PCH_H_STRB:
      begin
        if (cnt_q >= STROBE_CYC - 1 && link.wait_b) // see [R15]
        begin
          rdata_d  = link.card_data_bus;
          strb_b_d = 4'hF;
          st_d     = PCH_H_REL;
        end
      end
      PCH_H_REL:
      begin
        ce_b_d  = 2'b11;
        reg_b_d = 1'b1; // see [R7] [R10]
        doe_d   = 1'b0;
        rsp_d   = ~kind_q[0];
        rdy_d   = 1'b1;
        st_d    = PCH_H_IDLE;
      end
      default:
      begin
        st_d = PCH_H_PWR;
      end
    endcase
    if (sec_reset)
    begin
      st_d     = PCH_H_INIT;
      cnt_d    = 32'h0;
      ce_b_d   = 2'b11;
      reg_b_d  = 1'b1;
      strb_b_d = 4'hF;
      doe_d    = 1'b0;
      rdy_d    = 1'b0;
      rsp_d    = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q     <= PCH_H_PWR;
      cnt_q    <= 32'h0;
      kind_q   <= PCH_ATTR_RD;
      addr_q   <= 11'h000;
      ce_b_q   <= 2'b11;
      reg_b_q  <= 1'b1;
      strb_b_q <= 4'hF;
      dout_q   <= 16'h0000;
      doe_q    <= 1'b0;
      prst_q   <= 1'b1;
      srst_q   <= 1'b0;
      rdy_q    <= 1'b0;
      rsp_q    <= 1'b0;
      rdata_q  <= 16'h0000;
    end
    else
    begin
      st_q     <= st_d;
      cnt_q    <= cnt_d;
      kind_q   <= kind_d;
      addr_q   <= addr_d;
      ce_b_q   <= ce_b_d;
      reg_b_q  <= reg_b_d;
      strb_b_q <= strb_b_d;
      dout_q   <= dout_d;
      doe_q    <= doe_d;
      prst_q   <= prst_d;
      srst_q   <= srst_d;
      rdy_q    <= rdy_d;
      rsp_q    <= rsp_d;
      rdata_q  <= rdata_d;
    end
  end

  assign link.host_data_out      = dout_q; // see [R1]
  assign link.host_data_oe       = doe_q;
  assign link.card_address_bus   = addr_q;
  assign link.ce1_b              = ce_b_q[0];
  assign link.ce2_b              = ce_b_q[1];
  assign link.reg_b              = reg_b_q;
  assign link.oe_b               = strb_b_q[3];
  assign link.we_b               = strb_b_q[2];
  assign link.iord_b             = strb_b_q[1];
  assign link.iowr_b             = strb_b_q[0];
  assign link.primary_hw_reset   = prst_q;
  assign link.secondary_hw_reset = srst_q;
  assign cmd_ready               = rdy_q;
  assign rsp_valid               = rsp_q;
  assign rsp_data                = rdata_q;
endmodule : pch_card_host
`default_nettype wire

// File: tb/pch_link_props.sv
// Concurrent checks on the card link between the host end and the card end.
`default_nettype none
module pch_link_props (
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic [15:0] card_data_out,
  input wire logic        card_data_oe,
  input wire logic        host_data_oe,
  input wire logic [10:0] card_address_bus,
  input wire logic        ce1_b,
  input wire logic        ce2_b,
  input wire logic        reg_b,
  input wire logic        oe_b,
  input wire logic        we_b,
  input wire logic        iord_b,
  input wire logic        iowr_b,
  input wire logic        wait_b,
  input wire logic        primary_hw_reset,
  input wire logic        secondary_hw_reset
);
  timeunit 1ns;
  timeprecision 1ps;
  import pch_pkg::*;
  logic cfg_seen_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Set by an attribute write at the configuration location, cleared by either link reset.
  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b)
      cfg_seen_q <= 1'b0;
    else if (primary_hw_reset || secondary_hw_reset)
      cfg_seen_q <= 1'b0;
    else if (!reg_b && !we_b && !ce1_b && card_address_bus == CFG_REG_ADDR)
      cfg_seen_q <= 1'b1;
  AST_WAIT_CAUSE: assert property (
    $fell(wait_b) |-> $past(iord_b) == 1'b0 || $past(iowr_b) == 1'b0)
    else $error("wait asserted without an I/O strobe");
  AST_WAIT_CFG: assert property ($fell(wait_b) |-> cfg_seen_q)
    else $error("I/O cycle answered before configuration");
  AST_WAIT_STRETCH: assert property (
    cfg_seen_q && $fell(iord_b) |-> ##[1:3] !wait_b)
    else $error("configured I/O read not stretched");
  AST_WAIT_BOUND: assert property (!wait_b |-> ##[1:40] wait_b)
    else $error("wait held too long");
  AST_DRIVE_WINDOW: assert property (
    card_data_oe |-> oe_b == 1'b0 || iord_b == 1'b0 || $past(oe_b) == 1'b0 ||
    $past(iord_b) == 1'b0)
    else $error("card drives data outside a read strobe");
  AST_NO_CLASH: assert property (!(card_data_oe && host_data_oe))
    else $error("both ends drive the data bus");
  AST_REG_GATE: assert property ($rose(card_data_oe) |-> $past(reg_b) == 1'b0)
    else $error("card answered a common memory access");
  AST_ATTR_HIGH_BYTE: assert property (
    card_data_oe && iord_b && $past(iord_b) |-> card_data_out[15:8] == 8'h00)
    else $error("attribute read high byte not zero");
  AST_RESET_WAIT: assert property (
    primary_hw_reset || secondary_hw_reset |=> wait_b)
    else $error("wait not released under link reset");
  AST_INIT_CE: assert property (
    $fell(primary_hw_reset) |-> (ce1_b && ce2_b) [*8])
    else $error("card enabled during initialisation");
  cover property ($rose(card_data_oe) && iord_b);
  cover property ($fell(wait_b));
  cover property (!reg_b && !we_b && card_address_bus == CFG_REG_ADDR);
endmodule : pch_link_props
`default_nettype wire

// File: tb/pch_card_host_bench.sv
// Self-checking bench joining the host end and the card end.
`default_nettype none
module pch_card_host_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import pch_pkg::*;
  typedef struct {
    pch_cmd_t    k;
    logic [10:0] a;
    logic [15:0] d;
    logic [1:0]  l;
    logic [15:0] rsp;
    logic        mode;
    logic [7:0]  cfg;
  } pch_row_t;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic        cmd_valid = 1'b0;
  pch_cmd_t    cmd_kind = PCH_ATTR_RD;
  logic [10:0] cmd_addr = 11'h000;
  logic [15:0] cmd_wdata = 16'h0000;
  logic [1:0]  cmd_lanes = 2'h0;
  logic        sec_reset = 1'b0;
  logic        cmd_ready, rsp_valid, io_req, io_wr, io_mode, io_ack = 1'b0;
  logic [15:0] rsp_data, io_wdata, io_rdata = 16'h0000, rsp_q = 16'h0000, wd_q;
  logic [10:0] io_addr, ad_q;
  logic [1:0]  io_be, be_q;
  logic [7:0]  card_config;
  int          fail_count = 0, checked = 0, req_n = 0, ack_cnt = 0;
  pch_row_t    rows [10] = '{
    '{PCH_IO_RD,   11'h010, 16'h0000, 2'h3, 16'h0000, 1'b0, 8'h00},
    '{PCH_ATTR_WR, 11'h004, 16'h12A5, 2'h1, 16'h0000, 1'b0, 8'h00},
    '{PCH_ATTR_WR, 11'h005, 16'h3300, 2'h2, 16'h0000, 1'b0, 8'h00},
    '{PCH_ATTR_WR, 11'h005, 16'h0077, 2'h1, 16'h0000, 1'b0, 8'h00},
    '{PCH_ATTR_RD, 11'h004, 16'h0000, 2'h1, 16'h00A5, 1'b0, 8'h00},
    '{PCH_ATTR_WR, 11'h006, 16'h9966, 2'h3, 16'h0000, 1'b0, 8'h00},
    '{PCH_ATTR_RD, 11'h006, 16'h0000, 2'h3, 16'h0066, 1'b0, 8'h00},
    '{PCH_ATTR_WR, 11'h200, 16'h0041, 2'h1, 16'h0000, 1'b1, 8'h41},
    '{PCH_IO_WR,   11'h010, 16'hBEEF, 2'h3, 16'h0000, 1'b1, 8'h41},
    '{PCH_IO_RD,   11'h011, 16'h0000, 2'h3, 16'h105A, 1'b1, 8'h41}};

  always #2.5 mclk = ~mclk;
  pch_link_if pch_link_if_i ();
  pch_card_host #(.INIT_CYC_P(50), .RST_CYC_P(20)) pch_card_host_i (
    .mclk(mclk), .rst_b(rst_b), .link(pch_link_if_i.host), .cmd_valid(cmd_valid),
    .cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_lanes(cmd_lanes), .sec_reset(sec_reset), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  pch_card_dev #(.ATTR_WORDS(64)) pch_card_dev_i (
    .mclk(mclk), .rst_b(rst_b), .link(pch_link_if_i.card), .io_req(io_req),
    .io_wr(io_wr), .io_addr(io_addr), .io_wdata(io_wdata), .io_be(io_be),
    .io_ack(io_ack), .io_rdata(io_rdata), .io_mode(io_mode), .card_config(card_config));
  pch_link_props pch_link_props_i (
    .mclk(mclk), .rst_b(rst_b), .card_data_out(pch_link_if_i.card_data_out),
    .card_data_oe(pch_link_if_i.card_data_oe), .host_data_oe(pch_link_if_i.host_data_oe),
    .card_address_bus(pch_link_if_i.card_address_bus), .ce1_b(pch_link_if_i.ce1_b),
    .ce2_b(pch_link_if_i.ce2_b), .reg_b(pch_link_if_i.reg_b), .oe_b(pch_link_if_i.oe_b),
    .we_b(pch_link_if_i.we_b), .iord_b(pch_link_if_i.iord_b),
    .iowr_b(pch_link_if_i.iowr_b), .wait_b(pch_link_if_i.wait_b),
    .primary_hw_reset(pch_link_if_i.primary_hw_reset),
    .secondary_hw_reset(pch_link_if_i.secondary_hw_reset));

  // User side of the card: logs each I/O request and acknowledges it six cycles later.
  always @(posedge mclk)
  begin
    io_ack <= 1'b0;
    if (rsp_valid === 1'b1)
      rsp_q <= rsp_data;
    if (io_req === 1'b1)
    begin
      req_n <= req_n + 1;
      ad_q <= io_addr;
      wd_q <= io_wdata;
      be_q <= io_be;
      io_rdata <= {io_addr[7:0], 8'h5A};
      ack_cnt <= 6;
    end
    else if (ack_cnt != 0)
    begin
      ack_cnt <= ack_cnt - 1;
      io_ack <= (ack_cnt == 1);
    end
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wait_ready();
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 500)
    begin
      @(posedge mclk);
      n++;
    end
    if (n >= 500)
      check("cmd_ready", {15'h0, cmd_ready}, 16'h0001);
  endtask : wait_ready

  task automatic run_cmd(input pch_row_t r);
    wait_ready();
    cmd_valid <= 1'b1;
    cmd_kind <= r.k;
    cmd_addr <= r.a;
    cmd_wdata <= r.d;
    cmd_lanes <= r.l;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    @(posedge mclk);
    wait_ready();
    repeat (3) @(posedge mclk);
  endtask : run_cmd

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  initial
  begin
    #100000;
    fail_count++;
    end_of_test();
  end

  initial
  begin
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    @(posedge mclk);
    check("wait_b", {15'h0, pch_link_if_i.wait_b}, 16'h0001);
    check("primary", {15'h0, pch_link_if_i.primary_hw_reset}, 16'h0001);
    $display("test reset done");
    foreach (rows[i])
    begin
      run_cmd(rows[i]);
      if (rows[i].k == PCH_IO_RD || rows[i].k == PCH_ATTR_RD)
        check("rsp_data", rsp_q, rows[i].rsp);
      check("io_mode", {15'h0, io_mode}, {15'h0, rows[i].mode});
      check("card_config", {8'h0, card_config}, {8'h0, rows[i].cfg});
      if (rows[i].k == PCH_IO_WR)
        check("io_wdata", wd_q, rows[i].d);
      $display("test row %0d done", i);
    end
    check("io_addr", {5'h0, ad_q}, 16'h0010);
    check("io_be", {14'h0, be_q}, 16'h0003);
    check("io_req count", req_n[15:0], 16'h0002);
    sec_reset <= 1'b1;
    repeat (4) @(posedge mclk);
    sec_reset <= 1'b0;
    repeat (3) @(posedge mclk);
    check("io_mode", {15'h0, io_mode}, 16'h0000);
    check("card_config", {8'h0, card_config}, 16'h0000);
    run_cmd(rows[9]);
    check("rsp_data", rsp_q, 16'h0000);
    check("io_req count", req_n[15:0], 16'h0002);
    $display("test secondary reset done");
    end_of_test();
  end
endmodule : pch_card_host_bench
`default_nettype wire
